// >>> dv/jsr_jtag_master.sv
// jtag master model: walks the tap and shifts data paths
`timescale 1ns/10ps
`default_nettype none
module jsr_jtag_master (
    input wire logic clk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    // tck rests low between frames, tms high keeps the tap parked
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 160 ns tck period; tms and tdi held from fall to past the rise
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        repeat (8) @(negedge clk);
        o = tdo;
        tck = 1'b1;
        repeat (8) @(negedge clk);
        tck = 1'b0;
    endtask
    // stay in run-test/idle; the bench asks for enough self test clocks
    task automatic idle(input int n);
        logic o;
        repeat (n) tick(1'b0, 1'b0, o);
    endtask
    // five tms-high rises always reach test-logic-reset, then idle
    task automatic reset_tap();
        logic o;
        repeat (5) tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
    // idle, capture, n shifts lsb first, update, back to idle
    task automatic scan(input int n, input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b0, o);
        tick(1'b0, 1'b0, o);
    endtask
endmodule
`default_nettype wire

// >>> dv/tb_jtag_status_readout_memory_selftest_instr.sv
// self-checking bench for the jtag status, fifo drain, self test and coretest port
`timescale 1ns/10ps
`default_nettype none
module tb_jtag_status_readout_memory_selftest_instr
    import jsr_pkg::*;
;
    localparam int CYC = 16; // shortened self test count
    logic refClk, resetn, tck, tms, tdi, tdo, tdoEnN, lockIn, fifoValid, fifoPop, normEn;
    logic pllB, dllB, glbB, roMode, setupLd, spare, pllOut, dllOut, glbOut, stMode, coreDrive;
    jsr_instr_t instr;
    logic [1:0] tmSel;
    logic [ERR_W-1:0] errIn;
    jsr_occ_t occIn;
    logic [4:0] memErr;
    logic [9:0] stRes;
    logic [7:0] coreIn, coreOut;
    logic [31:0] fifoData;
    logic [31:0] fifoQ[$];
    logic [63:0] dout;
    // status rows: {spare, lock, occupancies, errors}
    logic [61:0] rows [3] = '{62'h2123456789abcdef, 62'h1fedcba987654321, 62'h30000000000007ff};
    int failures, cmpCount, pops, pllN, dllN, glbN;
    jsr_pins_t pins;
    assign pins = {tck, tms, tdi, instr, pllB, dllB, glbB, roMode, tmSel, setupLd, spare};
    initial begin
        refClk = 1'b0;
        forever #5 refClk = ~refClk;
    end
    jsr_jtag_master u_master (.clk(refClk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    jsr_top #(.CORE_BITS(8), .SELFTEST_CYCLES(CYC)) u_dut (.ref_clk(refClk), .resetn(resetn),
        .jtagPins(pins), .tdo(tdo), .tdoOutEnN(tdoEnN), .errIn(errIn), .occIn(occIn), .dllLockIn(lockIn),
        .fifoValid(fifoValid), .fifoData(fifoData), .fifoPop(fifoPop), .normalReadoutEn(normEn),
        .pllResetOut(pllOut), .dllResetOut(dllOut), .globalResetOut(glbOut), .selftestMode(stMode),
        .memErr(memErr), .selftestResult(stRes), .coreTestIn(coreIn), .coreTestOut(coreOut),
        .coreTestDrive(coreDrive));
    // fifo head presented off the sampling edge
    always @(negedge refClk) begin
        fifoValid = fifoQ.size() > 0;
        fifoData = fifoValid ? fifoQ[0] : 32'h0;
    end
    // pop words and count every pulse the design gives
    always @(posedge refClk) begin
        if (fifoPop === 1'b1) begin
            pops++;
            void'(fifoQ.pop_front());
        end
        pllN += int'(pllOut === 1'b1);
        dllN += int'(dllOut === 1'b1);
        glbN += int'(glbOut === 1'b1);
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmpCount++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // control bit written one then returned to zero
    task automatic pulse(ref logic b);
        b = 1'b1;
        repeat (20) @(negedge refClk);
        b = 1'b0;
        repeat (20) @(negedge refClk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog well beyond the expected run of about 11k cycles
    initial begin
        #600us;
        failures++;
        print_verdict();
    end
    initial begin
        {resetn, pllB, dllB, glbB, roMode, setupLd, spare, lockIn} = '0;
        {errIn, occIn, memErr, coreIn, tmSel} = '0;
        instr = INSTR_STATUS;
        repeat (16) @(negedge refClk);
        chk("tdo enable in reset", 64'h1, tdoEnN);
        chk("selftest reset", 64'h2aa, stRes);
        resetn = 1'b1;
        repeat (8) @(negedge refClk);
        u_master.reset_tap();
        $display("reset test done");
        // status rows: snapshot taken at capture, fields in order
        foreach (rows[i]) begin
            {spare, lockIn, occIn, errIn} = rows[i];
            repeat (10) @(negedge refClk);
            u_master.scan(62, 64'h0, dout);
            chk("status", {2'b00, rows[i] ^ (62'h1 << 61)}, dout);
        end
        $display("status rows done");
        // drain: two words, then empty, then mode off refuses
        fifoQ = '{32'hdeadbeef, 32'h01234567};
        instr = INSTR_READOUT;
        roMode = 1'b1;
        repeat (10) @(negedge refClk);
        chk("normal readout off", 64'h0, normEn);
        u_master.scan(33, 64'h0, dout);
        u_master.scan(33, 64'h0, dout);
        chk("drain word 0", {31'h0, 32'hdeadbeef, 1'b1}, dout);
        u_master.scan(33, 64'h0, dout);
        chk("drain word 1", {31'h0, 32'h01234567, 1'b1}, dout);
        u_master.scan(33, 64'h0, dout);
        chk("drain empty", 64'h0, dout);
        chk("pop count", 64'h2, pops);
        fifoQ.push_back(32'h55aa00ff);
        roMode = 1'b0;
        repeat (10) @(negedge refClk);
        chk("normal readout on", 64'h1, normEn);
        u_master.scan(33, 64'h0, dout);
        chk("no pop with mode off", 64'h2, pops);
        $display("drain test done");
        // loop bring-up: setup, pll, then dll; global reset leaves lock alone
        instr = INSTR_STATUS;
        lockIn = 1'b1;
        pulse(setupLd);
        pulse(pllB);
        // a global reset while lock is lost must not end the loss
        pulse(glbB);
        u_master.scan(62, 64'h0, dout);
        chk("lock lost after setup", 64'h0, dout[60]);
        chk("pll pulses", 64'h1, pllN);
        pulse(dllB);
        u_master.scan(62, 64'h0, dout);
        chk("lock after dll reset", 64'h1, dout[60]);
        pulse(glbB);
        u_master.scan(62, 64'h0, dout);
        chk("lock after global reset", 64'h1, dout[60]);
        chk("dll and global pulses", 64'h12, {dllN[3:0], glbN[3:0]});
        $display("loop test done");
        // self test: group 2 memory reports an error
        instr = INSTR_SELFTEST;
        memErr = 5'b00100;
        repeat (10) @(negedge refClk);
        chk("selftest mode", 64'h1, stMode);
        u_master.reset_tap();
        u_master.idle(2);
        chk("selftest running", 64'h2aa, stRes);
        u_master.idle(CYC + 4);
        chk("selftest result", 64'h175, stRes);
        u_master.scan(10, 64'h0, dout);
        chk("selftest scan", 64'h175, dout);
        $display("selftest done");
        // coretest: capture inputs, load outputs, drive with test mode set
        instr = INSTR_CORETEST;
        tmSel = 2'h1;
        coreIn = 8'ha5;
        repeat (10) @(negedge refClk);
        u_master.scan(8, 64'h3c, dout);
        chk("coretest capture", 64'ha5, dout);
        chk("coretest load", 9'h13c, {coreDrive, coreOut});
        $display("coretest done");
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> logic/jsr_memory_selftest_instr_unit.sv
// self test sequencer for one memory, counting tck edges in runbist
`timescale 1ns/10ps
`default_nettype none
module jsr_memory_selftest_instr_unit
    import jsr_pkg::*;
#(
    parameter int CYCLES = MEMORY_SELFTEST_INSTR_TCK_CYCLES
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic enterRun,
    input wire logic inRun,
    input wire logic tckRise,
    input wire logic memErr,
    output logic done,
    output logic fail
);
    // tck edges seen since runbist entry
    logic [15:0] count_reg;
    // any error seen in this run
    logic errSeen_reg;

    // entry restarts the test, edges in runbist advance it
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count_reg <= '0;
            errSeen_reg <= 1'b0;
            done <= 1'b0;
            fail <= 1'b1;
        end else if (enterRun) begin
            count_reg <= '0;
            errSeen_reg <= 1'b0;
            done <= 1'b0;
            fail <= 1'b1;
        end else if (inRun && tckRise && !done) begin
            count_reg <= count_reg + 16'h0001;
            errSeen_reg <= errSeen_reg | memErr;
            if (count_reg == 16'(CYCLES - 1)) begin
                done <= 1'b1;
                fail <= errSeen_reg | memErr;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    property p_entry_clears;
        enterRun |=> !done && fail;
    endproperty
    a_entry_clears: assert property (p_entry_clears) else $error("self test flags not restarted");

    property p_pass_needs_end;
        !fail |-> done;
    endproperty
    a_pass_needs_end: assert property (p_pass_needs_end) else $error("pass shown before test end");

    property p_end_count;
        $rose(done) |-> count_reg == 16'(CYCLES);
    endproperty
    a_end_count: assert property (p_end_count) else $error("test ended at wrong tck count");

    c_pass: cover property (@(posedge clk) $rose(done) && !fail);
endmodule
`default_nettype wire

// >>> logic/jsr_sync.sv
// two flip-flop synchroniser for a bundle of slow levels
`timescale 1ns/10ps
`default_nettype none
module jsr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    // first stage, read only by the second
    logic [W-1:0] meta_reg;

    // two stages; bundle members may skew by one cycle against each other
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            meta_reg <= '0;
            syncOut <= '0;
        end else begin
            meta_reg <= asyncIn;
            syncOut <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// >>> logic/jsr_top.sv
// jtag test port: loop reset sequencing, status snapshot, fifo drain, memory self test, coretest
// Contract
// - global reset leaves loop lock state alone
// - setup reload shows lock lost until reinit
// - status samples occupancies at read time
// - eleven-bit error vector in status bits 10:0
// - token, fifo fill, full, empty follow errors
// - four group fills, group 3 lowest
// - trigger fifo fill, flags, dll lock bit
// - jtag read-out mode disables normal read-out
// - each read-out update in jtag mode pops one fifo word if present
// - bit 0 valid, bits 32:1 the word
// - self test instruction puts memories in test
// - runbist 3200 tck; tests finish within that
// - ten-bit end/fail pairs, fifo first
// - end flag clears on entry, rises when done
// - fail flag sets on entry, clears on pass
// - coretest path reaches channel-to-buffer interface
`timescale 1ns/10ps
`default_nettype none
module jsr_top
    import jsr_pkg::*;
#(
    parameter int CORE_BITS = CORE_W,
    parameter int SELFTEST_CYCLES = MEMORY_SELFTEST_INSTR_TCK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire jsr_pins_t jtagPins,
    output logic tdo,
    output logic tdoOutEnN,
    input wire logic [ERR_W-1:0] errIn,
    input wire jsr_occ_t occIn,
    input wire logic dllLockIn,
    input wire logic fifoValid,
    input wire logic [WORD_W-1:0] fifoData,
    output logic fifoPop,
    output logic normalReadoutEn,
    output logic pllResetOut,
    output logic dllResetOut,
    output logic globalResetOut,
    output logic selftestMode,
    input wire logic [MEM_N-1:0] memErr,
    output logic [SELFTEST_W-1:0] selftestResult,
    input wire logic [CORE_BITS-1:0] coreTestIn,
    output logic [CORE_BITS-1:0] coreTestOut,
    output logic coreTestDrive
);
    // reset release through two stages
    logic rstMeta_reg;
    logic rstN;

    // async assert, clocked release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_reg <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstN <= rstMeta_reg;
        end
    end

    // jtag side levels in the ref_clk domain
    logic [$bits(jsr_pins_t)-1:0] pinsSyncRaw;
    jsr_pins_t pins;

    jsr_sync #(
        .W($bits(jsr_pins_t))
    ) u_pin_sync (
        .clk(ref_clk),
        .rstN(rstN),
        .asyncIn(jtagPins),
        .syncOut(pinsSyncRaw)
    );
    assign pins = jsr_pins_t'(pinsSyncRaw);

    // previous values for edge finding
    logic tckPrev_reg;
    logic pllRstPrev_reg;
    logic dllRstPrev_reg;
    logic globRstPrev_reg;
    logic setupLoadPrev_reg;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            tckPrev_reg <= 1'b0;
            pllRstPrev_reg <= 1'b0;
            dllRstPrev_reg <= 1'b0;
            globRstPrev_reg <= 1'b0;
            setupLoadPrev_reg <= 1'b0;
        end else begin
            tckPrev_reg <= pins.tck;
            pllRstPrev_reg <= pins.pllResetBit;
            dllRstPrev_reg <= pins.dllResetBit;
            globRstPrev_reg <= pins.globalResetBit;
            setupLoadPrev_reg <= pins.setupLoad;
        end
    end

    // edges of tck, one ref_clk cycle each
    logic tckRise;
    logic tckFall;
    assign tckRise = pins.tck & ~tckPrev_reg;
    assign tckFall = ~pins.tck & tckPrev_reg;

    // a reset bit acts when returned to zero, so a held one does nothing yet
    logic pllRstDone;
    logic dllRstDone;
    logic globRstDone;
    logic setupLoadRise;
    assign pllRstDone = ~pins.pllResetBit & pllRstPrev_reg;
    assign dllRstDone = ~pins.dllResetBit & dllRstPrev_reg;
    assign globRstDone = ~pins.globalResetBit & globRstPrev_reg;
    assign setupLoadRise = pins.setupLoad & ~setupLoadPrev_reg;

    // one-cycle reset pulses towards loops and core
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            pllResetOut <= 1'b0;
            dllResetOut <= 1'b0;
            globalResetOut <= 1'b0;
        end else begin
            pllResetOut <= pllRstDone;
            dllResetOut <= dllRstDone;
            globalResetOut <= globRstDone;
        end
    end

    // lock is shown lost after a setup reload until the dll is reset again
    logic lockLost_reg;

    // global reset is deliberately not an input here: loops keep their lock
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            lockLost_reg <= LOCK_LOST_RST;
        end else if (setupLoadRise) begin
            lockLost_reg <= 1'b1; // set wins over a coincident reinit
        end else if (dllRstDone) begin
            // dll reinit ends the loss; relies on pll locked and setup loaded first
            lockLost_reg <= 1'b0;
        end
    end

    logic dllLockShown;
    assign dllLockShown = dllLockIn & ~lockLost_reg & ~setupLoadRise;

    // tap controller stepped on each tck rise
    jsr_tap_t tap_reg;
    jsr_tap_t tapNext;

    always_comb begin
        tapNext = tap_reg;
        unique case (tap_reg)
            TAP_RESET: tapNext = pins.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tapNext = pins.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tapNext = pins.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tapNext = pins.tms ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tapNext = pins.tms ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_EX1_DR: tapNext = pins.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tapNext = pins.tms ? TAP_EX2_DR : TAP_PAUSE_DR;
            TAP_EX2_DR: tapNext = pins.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tapNext = pins.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tapNext = pins.tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tapNext = pins.tms ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tapNext = pins.tms ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_EX1_IR: tapNext = pins.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tapNext = pins.tms ? TAP_EX2_IR : TAP_PAUSE_IR;
            TAP_EX2_IR: tapNext = pins.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tapNext = pins.tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            tap_reg <= TAP_RESET;
        end else if (tckRise) begin
            tap_reg <= tapNext;
        end
    end

    // data register events, each one ref_clk cycle
    logic captureDr;
    logic shiftDr;
    logic updateDr;
    assign captureDr = tckRise && tap_reg == TAP_CAP_DR;
    assign shiftDr = tckRise && tap_reg == TAP_SHIFT_DR;
    assign updateDr = tckRise && tap_reg == TAP_UPD_DR;

    // running status image, msb first
    logic [STATUS_W-1:0] statusVec;
    assign statusVec = {~pins.setupSpare, dllLockShown, occIn, errIn};

    // self test: memories in test mode while the instruction is loaded
    assign selftestMode = pins.instr == INSTR_SELFTEST;

    // runbist is idle under the self test instruction
    logic inRunBist;
    logic enterRunBist;
    assign inRunBist = selftestMode && tap_reg == TAP_IDLE;
    assign enterRunBist = selftestMode && tckRise && tapNext == TAP_IDLE && tap_reg != TAP_IDLE;

    logic [MEM_N-1:0] memDone;
    logic [MEM_N-1:0] memFail;

    // unit 0 is the read-out fifo, units 1 to 4 groups 3 down to 0
    genvar gi;
    generate
        for (gi = 0; gi < MEM_N; gi++) begin : g_mem
            jsr_memory_selftest_instr_unit #(
                .CYCLES(SELFTEST_CYCLES)
            ) u_memory_selftest_instr (
                .clk(ref_clk),
                .rstN(rstN),
                .enterRun(enterRunBist),
                .inRun(inRunBist),
                .tckRise(tckRise),
                .memErr(memErr[gi]),
                .done(memDone[gi]),
                .fail(memFail[gi])
            );
            assign selftestResult[2*gi] = memDone[gi];
            assign selftestResult[2*gi+1] = memFail[gi];
        end
    endgenerate

    // group 0 outcome, the last pair of the result
    logic grp0SelftestDone;
    logic grp0SelftestBad;
    assign grp0SelftestDone = selftestResult[SELFTEST_W-2];
    assign grp0SelftestBad = selftestResult[SELFTEST_W-1];

    // jtag read-out mode steals the fifo from the normal interfaces
    assign normalReadoutEn = ~pins.jtagReadoutMode;

    // fifo drain register, loaded on update and shown on next capture
    jsr_drain_t drain_reg;
    logic popNow;
    assign popNow = updateDr && pins.instr == INSTR_READOUT && pins.jtagReadoutMode && fifoValid;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            drain_reg <= '0;
            fifoPop <= 1'b0;
        end else begin
            fifoPop <= popNow;
            if (updateDr && pins.instr == INSTR_READOUT && pins.jtagReadoutMode) begin
                // empty fifo gives a zero word with valid low
                drain_reg.valid <= fifoValid;
                drain_reg.word <= fifoValid ? fifoData : '0;
            end
        end
    end

    // scan path length for the selected instruction
    localparam int SHIFT_W = CORE_BITS > STATUS_W ? CORE_BITS : STATUS_W;
    logic [SHIFT_W-1:0] shift_reg;
    logic [SHIFT_W-1:0] shiftNext;
    int unsigned pathLen;

    always_comb begin
        unique case (pins.instr)
            INSTR_STATUS: pathLen = STATUS_W;
            INSTR_READOUT: pathLen = DRAIN_W;
            INSTR_SELFTEST: pathLen = SELFTEST_W;
            INSTR_CORETEST: pathLen = CORE_BITS;
            default: pathLen = 1;
        endcase
    end

    // one step towards tdo, tdi entering at the path's top bit
    always_comb begin
        shiftNext = '0;
        for (int i = 0; i < SHIFT_W; i++) begin
            if (i == int'(pathLen) - 1) begin
                shiftNext[i] = pins.tdi;
            end else if (i < int'(pathLen) - 1) begin
                shiftNext[i] = shift_reg[i+1];
            end
        end
    end

    // capture freezes the image so shifting sees no mid-change values
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            shift_reg <= '0;
        end else if (captureDr) begin
            unique case (pins.instr)
                INSTR_STATUS: shift_reg <= SHIFT_W'(statusVec);
                INSTR_READOUT: shift_reg <= SHIFT_W'(drain_reg);
                INSTR_SELFTEST: shift_reg <= SHIFT_W'(selftestResult);
                INSTR_CORETEST: shift_reg <= SHIFT_W'(coreTestIn);
                default: shift_reg <= '0;
            endcase
        end else if (shiftDr) begin
            shift_reg <= shiftNext;
        end
    end

    // coretest update drives the channel buffer to first level buffer interface
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            coreTestOut <= '0;
            coreTestDrive <= 1'b0;
        end else begin
            coreTestDrive <= pins.instr == INSTR_CORETEST && pins.testModeSel != TEST_MODE_OFF;
            if (updateDr && pins.instr == INSTR_CORETEST) begin
                coreTestOut <= shift_reg[CORE_BITS-1:0];
            end
        end
    end

    // tdo changes on the falling tck edge, driven only in shift-dr
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            tdo <= 1'b0;
            tdoOutEnN <= 1'b1;
        end else if (tckFall) begin
            tdo <= shift_reg[0];
            tdoOutEnN <= tap_reg != TAP_SHIFT_DR;
        end
    end

    default clocking cbt @(posedge ref_clk); endclocking
    default disable iff (!rstN);

    property p_pop_in_mode;
        fifoPop |-> $past(pins.jtagReadoutMode) && !normalReadoutEn;
    endproperty
    a_pop_in_mode: assert property (p_pop_in_mode) else $error("fifo popped outside jtag read-out mode");

    property p_pop_once;
        fifoPop |=> !fifoPop;
    endproperty
    a_pop_once: assert property (p_pop_once) else $error("more than one word popped per update");

    property p_pop_cause;
        popNow |=> fifoPop && drain_reg.valid && drain_reg.word == $past(fifoData);
    endproperty
    a_pop_cause: assert property (p_pop_cause) else $error("drain word or valid flag wrong");

    property p_empty_update;
        updateDr && pins.instr == INSTR_READOUT && pins.jtagReadoutMode && !fifoValid |=> !fifoPop && !drain_reg.valid;
    endproperty
    a_empty_update: assert property (p_empty_update) else $error("empty fifo update not flagged invalid");

    property p_status_capture;
        captureDr && pins.instr == INSTR_STATUS |=> shift_reg[STATUS_W-1:0] == $past(statusVec);
    endproperty
    a_status_capture: assert property (p_status_capture) else $error("status image not captured");

    property p_lock_lost_shown;
        setupLoadRise ##1 !dllRstDone |-> !dllLockShown && lockLost_reg;
    endproperty
    a_lock_lost_shown: assert property (p_lock_lost_shown) else $error("lock shown after setup reload");

    property p_global_keeps_lock;
        globalResetOut && lockLost_reg && !setupLoadRise && !dllRstDone |=> lockLost_reg;
    endproperty
    a_global_keeps_lock: assert property (p_global_keeps_lock) else $error("global reset touched loop state");

    property p_token_pos;
        captureDr && pins.instr == INSTR_STATUS |=> shift_reg[ST_TOKEN_BIT] == $past(occIn.haveToken)
            && shift_reg[ST_DLL_LOCK_BIT] == $past(dllLockShown);
    endproperty
    a_token_pos: assert property (p_token_pos) else $error("status token or lock bit misplaced");

    c_pop: cover property (fifoPop);
    c_lock_lost: cover property (setupLoadRise ##[1:20] dllRstDone);
    c_grp0_pass: cover property (grp0SelftestDone && !grp0SelftestBad);
    c_status_read: cover property (captureDr && pins.instr == INSTR_STATUS);
endmodule
`default_nettype wire

// >>> shared/jsr_pkg.sv
// package with widths, field positions, counts and carrier types for the jtag status readout block
package jsr_pkg;
    // scan path lengths and field widths
    localparam int STATUS_W = 62;
    localparam int DRAIN_W = 33;
    localparam int SELFTEST_W = 10;
    localparam int CORE_W = 344;
    localparam int ERR_W = 11;
    localparam int FILL_W = 8;
    localparam int TRIG_FILL_W = 4;
    localparam int WORD_W = 32;
    // number of memories under self test: read-out fifo plus four groups
    localparam int MEM_N = 5;
    // tck cycles in runbist until every memory test is over
    localparam int MEMORY_SELFTEST_INSTR_TCK_CYCLES = 3200;
    // status field positions
    localparam int ST_TOKEN_BIT = 11;
    localparam int ST_DLL_LOCK_BIT = 60;
    localparam int ST_SPARE_BIT = 61;
    // drain register field positions
    localparam int DR_VALID_BIT = 0;
    // test mode select pattern that keeps coretest drive off
    localparam logic [1:0] TEST_MODE_OFF = 2'h0;
    // reset values
    localparam logic LOCK_LOST_RST = 1'b0;

    // instruction selected by the outside instruction decoder
    typedef enum logic [2:0] {
        INSTR_OTHER,
        INSTR_STATUS,
        INSTR_READOUT,
        INSTR_SELFTEST,
        INSTR_CORETEST
    } jsr_instr_t;

    // tap controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR, TAP_PAUSE_DR, TAP_EX2_DR,
        TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } jsr_tap_t;

    // pins and scan latches arriving from the jtag side, msb first
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        jsr_instr_t instr;
        logic pllResetBit;
        logic dllResetBit;
        logic globalResetBit;
        logic jtagReadoutMode;
        logic [1:0] testModeSel;
        logic setupLoad;
        logic setupSpare;
    } jsr_pins_t;

    // core occupancies in status order, msb first (bits 59 down to 11)
    typedef struct packed {
        logic trigEmpty;
        logic trigFull;
        logic [TRIG_FILL_W-1:0] trigFill;
        logic [FILL_W-1:0] firstLevelFillGrp0;
        logic [FILL_W-1:0] firstLevelFillGrp1;
        logic [FILL_W-1:0] firstLevelFillGrp2;
        logic [FILL_W-1:0] firstLevelFillGrp3;
        logic roEmpty;
        logic roFull;
        logic [FILL_W-1:0] roFill;
        logic haveToken;
    } jsr_occ_t;

    // fifo drain scan word
    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic valid;
    } jsr_drain_t;
endpackage
